// *** nandc_flash_model.sv ***
/*
  Behavioural flash device that answers the host sequencer's pins.
  Assumes the bench resolves the shared bus and pulls the idle flag up.
*/
`timescale 1ns/1ns
module nandc_flash_model #(
  parameter int         BUSY_NS = 400,
  parameter logic [7:0] ID_BYTE = 8'h5A  // arbitrary value
) (
  input  wire logic       chip_select_n,
  input  wire logic       command_latch_select,
  input  wire logic       addr_latch_select,
  input  wire logic       write_strobe_n,
  input  wire logic       output_strobe_n,
  input  wire logic       protect_n,
  input  wire logic [7:0] bus,
  output logic      [7:0] dev_io,
  output logic            dev_busy
);
  logic [7:0]  page [4352];
  logic [7:0]  mem [int];
  logic [7:0]  abuf [5];
  logic [7:0]  q, mode;
  logic [7:0]  last_cmd;
  logic [12:0] col;
  logic [16:0] row;
  int          na, ncmd;
  logic        standby;
  initial begin
    mode = 8'h00;
    dev_busy = 1'b0;
    na = 0;
    ncmd = 0;
    q = 8'h00;
    col = '0;
  end
  assign standby = chip_select_n && !dev_busy;
  // released bus shows the flipped last value
  assign dev_io = (!chip_select_n && write_strobe_n && !output_strobe_n) ? q : ~q;
  task automatic go_busy();
    fork begin
      #40 dev_busy = 1'b1;
      #BUSY_NS dev_busy = 1'b0;
    end join_none
  endtask
  task automatic do_cmd(input logic [7:0] c);
    int dq[$];
    if (dev_busy && c != 8'h70 && c != 8'h71 && c != 8'hFF) return;
    ncmd++;
    last_cmd = c;
    row = {abuf[4][0], abuf[3], abuf[2]};
    case (c)
      8'h80: begin
        na = 0;
        foreach (page[k]) page[k] = 8'hFF;
      end
      8'h00, 8'h05, 8'h85, 8'h8C, 8'h90: begin
        na = 0;
        mode = c;
      end
      8'h60: na = 2;
      8'h30, 8'h31, 8'h3A, 8'h3F: begin
        for (int k = 0; k < 4352; k++)
          page[k] = mem.exists({row, k[12:0]}) ? mem[{row, k[12:0]}] : 8'hFF;
        go_busy();
      end
      8'h10, 8'h15: if (protect_n) begin
        foreach (page[k]) if (page[k] !== 8'hFF) mem[{row, k[12:0]}] = page[k];
        go_busy();
      end
      8'hD0: if (protect_n) begin
        foreach (mem[j]) if (j[29:19] == row[16:6]) dq.push_back(j);
        foreach (dq[i]) mem.delete(dq[i]);
        go_busy();
      end
      8'h70, 8'h71: mode = c;
      8'hFF: na = 0;
      default: ;
    endcase
  endtask
  always @(posedge write_strobe_n) if (!chip_select_n) begin
    if (command_latch_select && !addr_latch_select) begin
      do_cmd(bus);
    end else if (addr_latch_select && !command_latch_select && !dev_busy && na < 5) begin
      abuf[na] = bus;
      na++;
      if (na == 2) col = {abuf[1][4:0], abuf[0]};
    end else if (!command_latch_select && !addr_latch_select && !dev_busy && col < 4352) begin
      page[col] = bus;
      col++;
    end
  end
  always @(negedge output_strobe_n) if (!chip_select_n) begin
    if (mode == 8'h70 || mode == 8'h71) begin
      q = {protect_n, !dev_busy, 6'h00};
    end else if (mode == 8'h90) begin
      q = ID_BYTE;
    end else if (!dev_busy) begin
      q = page[col];
      col++;
    end
  end
endmodule

// *** nandc_host.sv ***
/*
  Host-side sequencer that drives a page-organised NAND flash through its pins:
  command, address, data-in and data-out cycles, busy wait and write protect.
  Assumes the board pulls op_idle_flag up and resolves io_out/io_oe into the bus.
*/
`timescale 1ns/1ns
module nandc_host
  import nandc_pkg::*;
#(
  parameter int LEN_W = 13
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             req_valid,
  output logic                  req_ready,
  input  wire nandc_op_t        req_op,
  input  wire logic             req_alt,
  input  wire logic [COL_W-1:0] req_col,
  input  wire logic [ROW_W-1:0] req_row,
  input  wire logic [LEN_W-1:0] req_len,
  output logic                  req_refused,
  output logic                  done,
  input  wire logic             allow_write,
  input  wire logic [7:0]       wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic      [7:0]       rd_data,
  output logic                  rd_valid,
  output logic                  command_latch_select,
  output logic                  addr_latch_select,
  output logic                  chip_select_n,
  output logic                  write_strobe_n,
  output logic                  output_strobe_n,
  output logic                  protect_n,
  output logic      [7:0]       io_out,
  output logic                  io_oe,
  input  wire logic [7:0]       io_in,
  input  wire logic             op_idle_flag
);

  typedef enum logic [3:0] {
    S_IDLE, S_LAUNCH, S_WLO, S_WHI, S_RLO, S_RHI, S_WAIT, S_BUSY, S_DONE
  } nandc_state_t;

  typedef enum logic [2:0] {
    STEP_CMD1, STEP_ADDR, STEP_WDATA, STEP_CMD2, STEP_RDATA
  } nandc_step_t;

  typedef struct packed {
    nandc_state_t     state;
    nandc_step_t      step;
    nandc_plan_t      plan;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic [LEN_W-1:0] len;
    logic [2:0]       idx;
    logic [3:0]       cnt;
    logic             busy_pend;
    logic             cle;
    logic             ale;
    logic             ce_n;
    logic             we_n;
    logic             re_n;
    logic             prot_n;
    logic [7:0]       io;
    logic             oe;
    logic [7:0]       rd;
    logic             rd_vld;
    logic             done;
    logic             refused;
  } nandc_st_t;

  nandc_st_t   r_reg;
  nandc_st_t   r_next;
  nandc_plan_t req_plan;
  logic [8:0]  pins_sync;
  logic        idle_s;
  logic [7:0]  io_s;

  nandc_sync #(.WIDTH(9)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({op_idle_flag, io_in}),
    .sync_out (pins_sync)
  );

  assign idle_s = pins_sync[8];
  assign io_s   = pins_sync[7:0];

  // upper bits of the second and fifth cycles are sent low
  function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [COL_W-1:0] c,
                                           input logic [ROW_W-1:0] w);
    case (i)
      ADDR_COL_LO: addr_byte = c[7:0];
      ADDR_COL_HI: addr_byte = {3'h0, c[12:8]};
      ADDR_ROW_LO: addr_byte = w[7:0];
      ADDR_ROW_MI: addr_byte = w[15:8];
      default:     addr_byte = {7'h00, w[16]};
    endcase
  endfunction

  function automatic nandc_plan_t plan_of(input nandc_op_t op, input logic alt);
    nandc_plan_t p;
    logic [7:0]  commit;
    commit     = alt ? CMD_PROG_CACH : CMD_PROG2;
    p          = '0;
    p.has_addr = 1'b1;
    p.a_first  = ADDR_COL_LO;
    p.a_last   = ADDR_ROW_HI;
    case (op)
      NANDC_OP_READ: begin
        p.cmd1 = CMD_READ1; p.dir = NANDC_DIR_RD; p.has_cmd2 = 1'b1; p.cmd2 = CMD_READ2;
        p.busy = 1'b1;
      end
      NANDC_OP_PROG: begin
        p.cmd1 = CMD_PROG1; p.dir = NANDC_DIR_WR; p.has_cmd2 = 1'b1; p.cmd2 = commit;
        p.busy = 1'b1; p.writes = 1'b1;
      end
      NANDC_OP_PROG_OPEN: begin
        p.cmd1 = CMD_PROG1; p.dir = NANDC_DIR_WR; p.writes = 1'b1;
      end
      NANDC_OP_COL_IN: begin
        p.cmd1 = CMD_COL_IN; p.a_last = ADDR_COL_HI; p.dir = NANDC_DIR_WR; p.writes = 1'b1;
      end
      NANDC_OP_COMMIT: begin
        p.cmd1 = commit; p.has_addr = 1'b0; p.busy = 1'b1; p.writes = 1'b1;
      end
      NANDC_OP_COL_OUT: begin
        p.cmd1 = CMD_COL_OUT1; p.a_last = ADDR_COL_HI; p.dir = NANDC_DIR_RD;
        p.has_cmd2 = 1'b1; p.cmd2 = CMD_COL_OUT2;
      end
      NANDC_OP_CACHE_RD: begin
        p.cmd1 = alt ? CMD_CACHE_END : CMD_CACHE_RD; p.has_addr = 1'b0;
        p.dir = NANDC_DIR_RD; p.busy = 1'b1;
      end
      NANDC_OP_COPY_RD: begin
        p.cmd1 = CMD_READ1; p.dir = NANDC_DIR_RD; p.has_cmd2 = 1'b1; p.cmd2 = CMD_COPY_RD2;
        p.busy = 1'b1;
      end
      NANDC_OP_COPY_PROG: begin
        p.cmd1 = CMD_COPY_PRG1; p.dir = NANDC_DIR_WR; p.has_cmd2 = 1'b1; p.cmd2 = commit;
        p.busy = 1'b1; p.writes = 1'b1;
      end
      NANDC_OP_ERASE: begin
        p.cmd1 = CMD_ERASE1; p.a_first = ADDR_ROW_LO; p.has_cmd2 = 1'b1;
        p.cmd2 = CMD_ERASE2; p.busy = 1'b1; p.writes = 1'b1;
      end
      NANDC_OP_READ_ID: begin
        p.cmd1 = CMD_READ_ID; p.a_last = ADDR_COL_LO; p.dir = NANDC_DIR_RD;
      end
      NANDC_OP_STATUS: begin
        p.cmd1 = alt ? CMD_STATUS_MP : CMD_STATUS; p.has_addr = 1'b0; p.dir = NANDC_DIR_RD;
      end
      default: begin
        p.cmd1 = CMD_RESET; p.has_addr = 1'b0; p.busy = 1'b1;
      end
    endcase
    return p;
  endfunction

  assign req_plan = plan_of(req_op, req_alt);

  always_comb begin
    logic f_addr;
    logic f_data;
    logic f_cmd;
    f_addr          = 1'b0;
    f_data          = 1'b0;
    f_cmd           = 1'b0;
    r_next          = r_reg;
    r_next.rd_vld   = 1'b0;
    r_next.done     = 1'b0;
    r_next.refused  = 1'b0;
    r_next.prot_n   = allow_write;
    case (r_reg.state)
      S_IDLE: begin
        if (req_valid) begin
          if (req_plan.writes && !r_reg.prot_n) begin
            r_next.refused = 1'b1;
          end else begin
            r_next.plan  = req_plan;
            r_next.col   = req_col;
            r_next.row   = req_row;
            r_next.len   = req_len;
            r_next.step  = STEP_CMD1;
            r_next.ce_n  = 1'b0;
            r_next.state = S_LAUNCH;
          end
        end
      end
      S_LAUNCH: begin
        r_next.cnt   = 4'(WE_LO_CYC - 1);
        r_next.state = S_WLO;
        r_next.we_n  = 1'b0;
        r_next.oe    = 1'b1;
        r_next.cle   = 1'b0;
        r_next.ale   = 1'b0;
        case (r_reg.step)
          STEP_CMD1: begin
            r_next.cle = 1'b1;
            r_next.io  = r_reg.plan.cmd1;
          end
          STEP_ADDR: begin
            r_next.ale = 1'b1;
            r_next.io  = addr_byte(r_reg.idx, r_reg.col, r_reg.row);
          end
          STEP_CMD2: begin
            r_next.cle = 1'b1;
            r_next.io  = r_reg.plan.cmd2;
          end
          STEP_WDATA: begin
            if (wr_valid) begin
              r_next.io = wr_data;
            end else begin
              r_next.state = S_LAUNCH;
              r_next.we_n  = 1'b1;
            end
          end
          default: begin
            r_next.oe    = 1'b0;
            r_next.we_n  = 1'b1;
            r_next.re_n  = 1'b0;
            r_next.cnt   = 4'(RE_LO_CYC - 1);
            r_next.state = S_RLO;
          end
        endcase
      end
      S_WLO: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end else begin
          r_next.we_n  = 1'b1;
          r_next.cnt   = 4'(WE_HI_CYC - 1);
          r_next.state = S_WHI;
        end
      end
      S_WHI: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end else begin
          case (r_reg.step)
            STEP_CMD1: begin
              if (r_reg.plan.has_addr) begin
                r_next.step  = STEP_ADDR;
                r_next.idx   = r_reg.plan.a_first;
                r_next.state = S_LAUNCH;
              end else begin
                f_addr = 1'b1;
              end
            end
            STEP_ADDR: begin
              if (r_reg.idx == r_reg.plan.a_last) begin
                f_addr = 1'b1;
              end else begin
                r_next.idx   = r_reg.idx + 3'h1;
                r_next.state = S_LAUNCH;
              end
            end
            STEP_WDATA: begin
              r_next.len   = r_reg.len - 1'b1;
              r_next.state = S_LAUNCH;
              f_data       = (r_reg.len == LEN_W'(1));
            end
            default: f_cmd = 1'b1;
          endcase
          if (f_addr) begin
            if (r_reg.plan.dir == NANDC_DIR_WR && r_reg.len != '0) begin
              r_next.step  = STEP_WDATA;
              r_next.state = S_LAUNCH;
            end else begin
              f_data = 1'b1;
            end
          end
          if (f_data) begin
            if (r_reg.plan.has_cmd2) begin
              r_next.step  = STEP_CMD2;
              r_next.state = S_LAUNCH;
            end else begin
              f_cmd = 1'b1;
            end
          end
          if (f_cmd) begin
            r_next.state     = S_WAIT;
            r_next.busy_pend = r_reg.plan.busy;
            r_next.cnt       = r_reg.plan.busy ? 4'(WB_CYC - 1) : 4'(WHR_CYC - 1);
            r_next.cle       = 1'b0;
            r_next.ale       = 1'b0;
            r_next.oe        = 1'b0;
          end
        end
      end
      S_WAIT: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end else if (r_reg.busy_pend) begin
          r_next.state = S_BUSY;
        end else if (r_reg.plan.dir == NANDC_DIR_RD && r_reg.len != '0) begin
          r_next.step  = STEP_RDATA;
          r_next.state = S_LAUNCH;
        end else begin
          r_next.state = S_DONE;
        end
      end
      S_BUSY: begin
        // strobes stay high until the pulled-up flag reads idle
        if (idle_s) begin
          r_next.busy_pend = 1'b0;
          r_next.cnt       = 4'(WHR_CYC - 1);
          r_next.state     = S_WAIT;
        end
      end
      S_RLO: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end else begin
          r_next.rd     = io_s;
          r_next.rd_vld = 1'b1;
          r_next.re_n   = 1'b1;
          r_next.cnt    = 4'(RE_HI_CYC - 1);
          r_next.state  = S_RHI;
        end
      end
      S_RHI: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end else begin
          r_next.len   = r_reg.len - 1'b1;
          r_next.state = (r_reg.len == LEN_W'(1)) ? S_DONE : S_LAUNCH;
        end
      end
      S_DONE: begin
        r_next.done  = 1'b1;
        // an open program sequence keeps the chip selected for the next piece
        r_next.ce_n  = !(r_reg.plan.dir == NANDC_DIR_WR && !r_reg.plan.has_cmd2);
        r_next.state = S_IDLE;
      end
      default: r_next.state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg        <= '0;
      r_reg.ce_n   <= PIN_HIGH_RST;
      r_reg.we_n   <= PIN_HIGH_RST;
      r_reg.re_n   <= PIN_HIGH_RST;
      r_reg.prot_n <= PROT_N_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign req_ready            = (r_reg.state == S_IDLE);
  assign wr_ready             = (r_reg.state == S_LAUNCH) && (r_reg.step == STEP_WDATA);
  assign req_refused          = r_reg.refused;
  assign done                 = r_reg.done;
  assign rd_data              = r_reg.rd;
  assign rd_valid             = r_reg.rd_vld;
  assign command_latch_select = r_reg.cle;
  assign addr_latch_select    = r_reg.ale;
  assign chip_select_n        = r_reg.ce_n;
  assign write_strobe_n       = r_reg.we_n;
  assign output_strobe_n      = r_reg.re_n;
  assign protect_n            = r_reg.prot_n;
  assign io_out               = r_reg.io;
  assign io_oe                = r_reg.oe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_read_commit;
    $rose(write_strobe_n) && command_latch_select && io_out == CMD_READ2;
  endsequence

  chk_cmd_capture: assert property ($rose(write_strobe_n) && command_latch_select
    |-> $past(command_latch_select) && $stable(io_out) && io_oe)
    else $error("command latch dropped or data moved at write strobe rise");
  chk_addr_capture: assert property ($rose(write_strobe_n) && addr_latch_select
    |-> $past(addr_latch_select) && !command_latch_select && $stable(io_out))
    else $error("address latch dropped or data moved at write strobe rise");
  // the strobe-low window always carries the byte that matches idx; the next launch cycle may not
  chk_col_hi_bits: assert property (addr_latch_select && !write_strobe_n && r_reg.idx == ADDR_COL_HI
    |-> io_out[7:5] == 3'h0 && io_out[4:0] == r_reg.col[12:8])
    else $error("second address cycle has wrong bits");
  chk_row_hi_bits: assert property (addr_latch_select && !write_strobe_n && r_reg.idx == ADDR_ROW_HI
    |-> io_out == {7'h00, r_reg.row[16]})
    else $error("fifth address cycle has wrong bits");
  chk_cycle_class: assert property (!write_strobe_n
    |-> !chip_select_n && output_strobe_n && !(command_latch_select && addr_latch_select))
    else $error("write cycle with illegal latch or select levels");
  chk_busy_quiet: assert property (r_reg.state == S_BUSY
    |-> write_strobe_n && output_strobe_n && !io_oe && !chip_select_n)
    else $error("strobes active during busy");
  chk_read_busy: assert property (s_read_commit
    |-> ##1 (r_reg.state == S_WAIT)[*5] ##1 r_reg.state == S_BUSY)
    else $error("read commit not followed by busy wait");
  chk_idle_wait: assert property (r_reg.state == S_BUSY && !idle_s
    |=> r_reg.state == S_BUSY && $stable(write_strobe_n))
    else $error("left busy wait while flag low");

endmodule

// *** nandc_pkg.sv ***
/*
  Shared constants and types for the host-side NAND command/address sequencer.
  Assumes a single 50 MHz core clock; all pin timing is counted in its cycles.
*/
package nandc_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_STAGES   = 2;

  // pin timing, in ns as specified
  localparam int T_WP_NS  = 12;
  localparam int T_WH_NS  = 10;
  localparam int T_REA_NS = 20;
  localparam int T_REH_NS = 10;
  localparam int T_WHR_NS = 60;
  localparam int T_WB_NS  = 100;

  // least times round up, never below one cycle
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WE_LO_CYC = min_cyc(T_WP_NS);
  localparam int WE_HI_CYC = min_cyc(T_WH_NS);
  localparam int RE_LO_CYC = min_cyc(T_REA_NS) + SYNC_STAGES;
  localparam int RE_HI_CYC = min_cyc(T_REH_NS);
  localparam int WHR_CYC   = min_cyc(T_WHR_NS);
  localparam int WB_CYC    = min_cyc(T_WB_NS);

  // command codes
  localparam logic [7:0] CMD_READ1     = 8'h00;
  localparam logic [7:0] CMD_READ2     = 8'h30;
  localparam logic [7:0] CMD_COL_OUT1  = 8'h05;
  localparam logic [7:0] CMD_COL_OUT2  = 8'hE0;
  localparam logic [7:0] CMD_CACHE_RD  = 8'h31;
  localparam logic [7:0] CMD_CACHE_END = 8'h3F;
  localparam logic [7:0] CMD_PROG1     = 8'h80;
  localparam logic [7:0] CMD_PROG2     = 8'h10;
  localparam logic [7:0] CMD_PROG_CACH = 8'h15;
  localparam logic [7:0] CMD_COL_IN    = 8'h85;
  localparam logic [7:0] CMD_COPY_RD2  = 8'h3A;
  localparam logic [7:0] CMD_COPY_PRG1 = 8'h8C;
  localparam logic [7:0] CMD_ERASE1    = 8'h60;
  localparam logic [7:0] CMD_ERASE2    = 8'hD0;
  localparam logic [7:0] CMD_READ_ID   = 8'h90;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_STATUS_MP = 8'h71;
  localparam logic [7:0] CMD_RESET     = 8'hFF;

  // address cycle indices
  localparam logic [2:0] ADDR_COL_LO = 3'h0;
  localparam logic [2:0] ADDR_COL_HI = 3'h1;
  localparam logic [2:0] ADDR_ROW_LO = 3'h2;
  localparam logic [2:0] ADDR_ROW_MI = 3'h3;
  localparam logic [2:0] ADDR_ROW_HI = 3'h4;

  // geometry
  localparam int COL_W       = 13;
  localparam int ROW_W       = 17;
  localparam int PAGE_BYTES  = 4352;
  localparam int PAGE_POS_W  = 6;

  // values after reset
  localparam logic PIN_HIGH_RST = 1'b1;
  localparam logic PROT_N_RST   = 1'b0;

  typedef enum logic [3:0] {
    NANDC_OP_READ, NANDC_OP_PROG, NANDC_OP_PROG_OPEN, NANDC_OP_COL_IN, NANDC_OP_COMMIT,
    NANDC_OP_COL_OUT, NANDC_OP_CACHE_RD, NANDC_OP_COPY_RD, NANDC_OP_COPY_PROG,
    NANDC_OP_ERASE, NANDC_OP_READ_ID, NANDC_OP_STATUS, NANDC_OP_RESET
  } nandc_op_t;

  typedef enum logic [1:0] {NANDC_DIR_NONE, NANDC_DIR_WR, NANDC_DIR_RD} nandc_dir_t;

  typedef struct packed {
    logic [7:0] cmd1;
    logic       has_addr;
    logic [2:0] a_first;
    logic [2:0] a_last;
    nandc_dir_t dir;
    logic       has_cmd2;
    logic [7:0] cmd2;
    logic       busy;
    logic       writes;
  } nandc_plan_t;

endpackage

// *** nandc_sync.sv ***
/*
  Two-flop synchroniser for the bus inputs and the ready flag.
  Assumes inputs arrive asynchronous to core_clk; nothing reads the first stage.
*/
`timescale 1ns/1ns
module nandc_sync
  import nandc_pkg::*;
#(
  parameter int WIDTH = 9
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } nandc_sync_st_t;

  nandc_sync_st_t st_reg;
  nandc_sync_st_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = async_in;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.sync;

endmodule

// *** testbench.sv ***
/*
  Self-checking bench: host sequencer against the flash model.
  Assumes the model keeps written pages and reads unwritten bytes as FF.
*/
`timescale 1ns/1ns
module testbench;
  import nandc_pkg::*;
  logic             core_clk, sys_rst, req_valid, req_ready, req_alt, req_refused, done;
  logic             allow_write, wr_valid, wr_ready, rd_valid, io_oe, op_idle_flag;
  logic             command_latch_select, addr_latch_select, chip_select_n, dev_busy;
  logic             write_strobe_n, output_strobe_n, protect_n, got_done, got_ref;
  logic [7:0]       wr_data, rd_data, io_out, io_in, dev_io;
  logic [COL_W-1:0] req_col;
  logic [ROW_W-1:0] req_row;
  logic [12:0]      req_len;
  nandc_op_t        req_op;
  logic [7:0]       wq[$], rq[$];
  int               failures, comparisons;
  localparam logic [16:0] ROW_A = 17'h1_2345;
  localparam logic [16:0] ROW_B = 17'h0_0047;
  assign io_in = io_oe ? io_out : dev_io;
  assign op_idle_flag = dev_busy ? 1'b0 : 1'b1;
  nandc_host u_nandc_host (.core_clk, .sys_rst, .req_valid, .req_ready, .req_op, .req_alt,
    .req_col, .req_row, .req_len, .req_refused, .done, .allow_write, .wr_data, .wr_valid,
    .wr_ready, .rd_data, .rd_valid, .command_latch_select, .addr_latch_select,
    .chip_select_n, .write_strobe_n, .output_strobe_n, .protect_n, .io_out, .io_oe,
    .io_in, .op_idle_flag);
  nandc_flash_model u_nandc_flash_model (.chip_select_n, .command_latch_select,
    .addr_latch_select, .write_strobe_n, .output_strobe_n, .protect_n, .bus(io_in),
    .dev_io, .dev_busy);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkq(input string nm, input logic [7:0] e[$]);
    chk8(nm, 8'(e.size()), 8'(rq.size()));
    foreach (e[i]) chk8(nm, e[i], i < rq.size() ? rq[i] : ~e[i]);
  endtask
  task automatic run(input nandc_op_t op, input logic alt, input logic [12:0] col,
                     input logic [16:0] row, input logic [12:0] len);
    logic tk, wt;
    @(negedge core_clk);
    req_op = op;
    req_alt = alt;
    req_col = col;
    req_row = row;
    req_len = len;
    req_valid = 1'b1;
    got_done = 1'b0;
    got_ref = 1'b0;
    rq = {};
    for (int n = 0; n < 5000 && !got_done && !got_ref; n++) begin
      wr_valid = wq.size() > 0;
      wr_data = wq.size() > 0 ? wq[0] : 8'h00;
      @(posedge core_clk);
      tk = req_valid & req_ready;
      wt = wr_valid & wr_ready;
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      got_done = done === 1'b1;
      got_ref = req_refused === 1'b1;
      @(negedge core_clk);
      if (tk) req_valid = 1'b0;
      if (wt) void'(wq.pop_front());
    end
    wr_valid = 1'b0;
    chk1("op finished", 1'b1, got_done | got_ref);
  endtask
  task automatic t_refuse();
    int c0;
    nandc_op_t ops[3];
    c0 = u_nandc_flash_model.ncmd;
    ops = '{NANDC_OP_PROG, NANDC_OP_ERASE, NANDC_OP_COMMIT};
    foreach (ops[i]) begin
      run(ops[i], 1'b0, 13'h0000, ROW_A, 13'h0000);
      chk1("refused", 1'b1, got_ref);
    end
    chk8("cmds sent", 8'h00, 8'(u_nandc_flash_model.ncmd - c0));
  endtask
  task automatic t_prog_read();
    logic [7:0] ab[5];
    allow_write = 1'b1;
    repeat (3) @(negedge core_clk);
    wq = {8'hA1, 8'hB2};
    run(NANDC_OP_PROG, 1'b0, 13'h10FE, ROW_A, 13'h0002);
    chk1("prog done", 1'b1, got_done);
    ab = '{8'hFE, 8'h10, 8'h45, 8'h23, 8'h01};
    foreach (ab[i]) chk8("addr byte", ab[i], u_nandc_flash_model.abuf[i]);
    run(NANDC_OP_READ, 1'b0, 13'h10FE, ROW_A, 13'h0002);
    chkq("read", {8'hA1, 8'hB2});
    run(NANDC_OP_COL_OUT, 1'b0, 13'h10FF, ROW_A, 13'h0001);
    chkq("col jump", {8'hB2});
  endtask
  task automatic t_status_id();
    for (int a = 0; a < 2; a++) begin
      run(NANDC_OP_STATUS, a[0], 13'h0000, 17'h0_0000, 13'h0001);
      chkq("status", {8'hC0});
    end
    run(NANDC_OP_READ_ID, 1'b0, 13'h0000, 17'h0_0000, 13'h0001);
    chkq("id", {8'h5A});
  endtask
  task automatic t_col_in();
    wq = {8'h11};
    run(NANDC_OP_PROG_OPEN, 1'b0, 13'h0000, ROW_B, 13'h0001);
    wq = {8'h22};
    run(NANDC_OP_COL_IN, 1'b0, 13'h0005, ROW_B, 13'h0001);
    wq = {8'h33};
    run(NANDC_OP_COL_IN, 1'b0, 13'h0002, ROW_B, 13'h0001);
    run(NANDC_OP_COMMIT, 1'b1, 13'h0000, ROW_B, 13'h0000);
    chk1("commit done", 1'b1, got_done);
    run(NANDC_OP_READ, 1'b0, 13'h0000, ROW_B, 13'h0006);
    chkq("col in", {8'h11, 8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h22});
  endtask
  task automatic t_erase();
    run(NANDC_OP_ERASE, 1'b0, 13'h0000, ROW_A, 13'h0000);
    chk1("erase done", 1'b1, got_done);
    run(NANDC_OP_READ, 1'b0, 13'h10FE, ROW_A, 13'h0002);
    chkq("erased", {8'hFF, 8'hFF});
    run(NANDC_OP_READ, 1'b0, 13'h0000, ROW_B, 13'h0001);
    chkq("other block", {8'h11});
  endtask
  task automatic t_copy_cache();
    run(NANDC_OP_COPY_RD, 1'b0, 13'h0000, ROW_B, 13'h0001);
    chkq("copy src", {8'h11});
    run(NANDC_OP_COPY_PROG, 1'b0, 13'h0000, ROW_A, 13'h0000);
    chk8("copy cmd", 8'h10, u_nandc_flash_model.last_cmd);
    run(NANDC_OP_READ, 1'b0, 13'h0000, ROW_A, 13'h0006);
    chkq("copy dst", {8'h11, 8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h22});
    for (int a = 0; a < 2; a++) begin
      run(NANDC_OP_CACHE_RD, a[0], 13'h0000, ROW_A, 13'h0000);
      chk8("cache cmd", a[0] ? 8'h3F : 8'h31, u_nandc_flash_model.last_cmd);
    end
    run(NANDC_OP_RESET, 1'b0, 13'h0000, ROW_A, 13'h0000);
    chk8("reset cmd", 8'hFF, u_nandc_flash_model.last_cmd);
  endtask
  initial begin
    failures = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_op = NANDC_OP_READ;
    req_alt = 1'b0;
    req_col = '0;
    req_row = '0;
    req_len = '0;
    allow_write = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    t_refuse();
    t_prog_read();
    t_status_id();
    t_col_in();
    t_erase();
    t_copy_cache();
    finish_test();
  end
  initial begin
    #2_000_000;
    failures++;
    finish_test();
  end
endmodule
